// ===== psrs_map.svh
// Constants of the power-state and reset sequencer: timing counts and field layouts.
// Assumes a 250 MHz sequencer clock; included by bare name.
`ifndef PSRS_MAP_SVH
`define PSRS_MAP_SVH
`define PSRS_CLK_MHZ 250
`define PSRS_RC_STABLE_US 10
`define PSRS_RC_STABLE_CYC ((`PSRS_RC_STABLE_US * `PSRS_CLK_MHZ))
`define PSRS_SLOW_DIV 64
`define PSRS_RST_PERIODS 256
`define PSRS_CAP_CODE_W 3
`define PSRS_BOOST_BIT 1
`define PSRS_CAP_BASE_CPF 100
`define PSRS_CAP_STEP_CPF 125
`define PSRS_CAP_BOOST_CPF 500
`define PSRS_CAL_W 8
`define PSRS_BOD_W 4
`define PSRS_BOD_RESET 4'h8
`endif

// ===== psrs_pkg.sv
// Types of the power-state and reset sequencer.
// Assumes nothing of its surroundings.
package psrs_pkg;
	typedef enum logic [2:0] {
		PSRS_CORE_OFF,
		PSRS_PROC_ONLY,
		PSRS_RADIO_TX,
		PSRS_RADIO_RX,
		PSRS_DEEP_SLEEP
	} psrs_state_t;
	typedef enum logic [1:0] {
		PSRS_CMD_PROC_ONLY,
		PSRS_CMD_RADIO_TX,
		PSRS_CMD_RADIO_RX,
		PSRS_CMD_DEEP_SLEEP
	} psrs_cmd_t;
endpackage

// ===== psrs_sync.sv
// Three-stage input synchroniser; the output changes once stages two and three agree.
// Assumes an asynchronous level input.
`timescale 1ns/1ps
module psrs_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic async_i,
	output logic sync_o
);
	logic [2:0] sh_q;
	logic [2:0] sh_d;
	logic out_q;
	logic out_d;
	always_comb begin
		sh_d = {sh_q[1:0], async_i};
		out_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : out_q;
	end
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sh_q <= {3{RST_VAL}};
			out_q <= RST_VAL;
		end else begin
			sh_q <= sh_d;
			out_q <= out_d;
		end
	end
	assign sync_o = out_q;
endmodule

// ===== psrs_slowdiv.sv
// Divides the slow RC clock, sampled as a level, by 64 and marks each slow tick.
// Assumes the RC clock input is already synchronised to mclk_i.
`timescale 1ns/1ps
`include "psrs_map.svh"
module psrs_slowdiv #(
	parameter int DIV = `PSRS_SLOW_DIV
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic rc_i,
	input wire logic run_i,
	output logic tick_o,
	output logic sleep_clk_o
);
	logic prev_q;
	logic prev_d;
	logic [6:0] cnt_q;
	logic [6:0] cnt_d;
	logic tick_q;
	logic tick_d;
	logic clk_q;
	logic clk_d;
	always_comb begin
		prev_d = rc_i;
		cnt_d = cnt_q;
		tick_d = 1'b0;
		clk_d = clk_q;
		if (!run_i) begin
			cnt_d = 7'h0;
			clk_d = 1'b0;
		end else if (rc_i && !prev_q) begin
			if (cnt_q == 7'(DIV - 1)) begin
				cnt_d = 7'h0;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 7'h1;
			end
			clk_d = (cnt_d < 7'(DIV / 2));
		end
	end
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prev_q <= 1'b0;
			cnt_q <= 7'h0;
			tick_q <= 1'b0;
			clk_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			cnt_q <= cnt_d;
			tick_q <= tick_d;
			clk_q <= clk_d;
		end
	end
	assign tick_o = tick_q;
	assign sleep_clk_o = clk_q;
endmodule

// ===== psrs_seq.sv
// Power-state and reset sequencer: chip enable, reset hold, clock choice, crystal load code.
// Assumes analog flags and the RC clock arrive asynchronously; commands come from software.
//
// Overview of operation
// - Radio states always keep the processor domain powered.
// - States: core off, processor only, transmit, receive, deep sleep.
// - Low chip enable holds core off; rising enters processor only; falling returns.
// - Past processor only, software commands move between power states; losing enable or reset returns to core off.
// - Wait at least 10 us after chip enable before trusting slow clock.
// - Power-on flag follows the battery supply comparator.
// - Brownout flag follows the bandgap comparator with programmable threshold.
// - Reset held for 256 periods of 64 slow RC cycles.
// - Sleep clock is the 2 MHz RC divided by 64.
// - Processor clock drives processor and serial interfaces, nominally 26 MHz.
// - Crystal clock chosen whenever radio runs or accuracy is requested.
// - RC clock may serve as reduced-speed processor clock.
// - Low-power clock drives sleep timer, sequencer and always-on timer.
// - Three-bit load code selects 1.00 to 9.75 pF; boost adds 5 pF.
// - Crystal offset calibration is taken from fuse storage.
`timescale 1ns/1ps
`include "psrs_map.svh"
module psrs_seq #(
	parameter int RST_PERIODS = `PSRS_RST_PERIODS,
	parameter int RC_STABLE_CYC = `PSRS_RC_STABLE_CYC
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic io_supply_i,
	input wire logic chip_enable_pin_i,
	input wire logic battery_low_cmp_i,
	input wire logic bandgap_low_cmp_i,
	input wire logic slow_rc_clk_i,
	input wire logic cmd_valid_i,
	input wire psrs_pkg::psrs_cmd_t cmd_i,
	input wire logic accurate_clk_req_i,
	input wire logic low_power_clk_fast_i,
	input wire logic [`PSRS_BOD_W-1:0] bod_threshold_i,
	input wire logic [`PSRS_CAP_CODE_W-1:0] xo_load_cap_code_i,
	input wire logic [1:0] xo_cap_boost_reg_i,
	input wire logic [`PSRS_CAL_W-1:0] fuse_xo_cal_i,
	output psrs_pkg::psrs_state_t power_state_o,
	output logic proc_power_on_o,
	output logic radio_power_on_o,
	output logic power_on_reset_flag_o,
	output logic brownout_flag_o,
	output logic chip_reset_n_o,
	output logic slow_clk_stable_o,
	output logic proc_clk_sel_xo_o,
	output logic lp_clk_sel_div_o,
	output logic sleep_clk_o,
	output logic [`PSRS_BOD_W-1:0] bod_threshold_o,
	output logic [10:0] xo_load_cap_cpf_o,
	output logic [`PSRS_CAL_W-1:0] xo_offset_cal_o
);
	import psrs_pkg::*;

	// ==========================================================
	// Input synchronisers
	logic io_s;
	logic ce_s;
	logic por_s;
	logic bod_s;
	logic rc_s;
	psrs_sync u_sync_io (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.async_i(io_supply_i),
		.sync_o(io_s)
	);
	psrs_sync u_sync_ce (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.async_i(chip_enable_pin_i),
		.sync_o(ce_s)
	);
	// The power-on flag resets high, so its synchroniser does too and shows no false release.
	psrs_sync #(
		.RST_VAL(1'b1)
	) u_sync_por (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.async_i(battery_low_cmp_i),
		.sync_o(por_s)
	);
	psrs_sync u_sync_bod (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.async_i(bandgap_low_cmp_i),
		.sync_o(bod_s)
	);
	psrs_sync u_sync_rc (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.async_i(slow_rc_clk_i),
		.sync_o(rc_s)
	);

	// The enable only counts with the I/O supply up, so a stray high enable stays harmless.
	logic enable;
	assign enable = ce_s && io_s;

	// ==========================================================
	// Slow clock divider and stabilisation wait
	logic slow_tick;
	logic sleep_clk;
	logic [15:0] stab_cnt_q;
	logic [15:0] stab_cnt_d;
	logic stable_q;
	logic stable_d;
	logic hold_clr;
	// Restarting the divider with the hold counter makes every hold a full count of slow
	// periods; the price is that the sleep clock pauses while a reset flag is up.
	assign hold_clr = por_s || bod_s || !stable_q;
	psrs_slowdiv u_div (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.rc_i(rc_s),
		.run_i(!hold_clr),
		.tick_o(slow_tick),
		.sleep_clk_o(sleep_clk)
	);

	always_comb begin
		stab_cnt_d = stab_cnt_q;
		stable_d = stable_q;
		if (!enable) begin
			stab_cnt_d = 16'h0;
			stable_d = 1'b0;
		end else if (!stable_q) begin
			if (stab_cnt_q >= 16'(RC_STABLE_CYC - 1)) begin
				stable_d = 1'b1;
			end else begin
				stab_cnt_d = stab_cnt_q + 16'h1;
			end
		end
	end
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stab_cnt_q <= 16'h0;
			stable_q <= 1'b0;
		end else begin
			stab_cnt_q <= stab_cnt_d;
			stable_q <= stable_d;
		end
	end

	// ==========================================================
	// Reset flags and reset hold counter
	logic por_q;
	logic por_d;
	logic bod_q;
	logic bod_d;
	logic [8:0] hold_cnt_q;
	logic [8:0] hold_cnt_d;
	logic rst_n_q;
	logic rst_n_d;
	always_comb begin
		por_d = por_s;
		bod_d = bod_s;
		hold_cnt_d = hold_cnt_q;
		rst_n_d = rst_n_q;
		if (hold_clr) begin
			hold_cnt_d = 9'h0;
			rst_n_d = 1'b0;
		end else if (!rst_n_q && slow_tick) begin
			if (hold_cnt_q == 9'(RST_PERIODS - 1)) begin
				rst_n_d = 1'b1;
			end else begin
				hold_cnt_d = hold_cnt_q + 9'h1;
			end
		end
	end
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			por_q <= 1'b1;
			bod_q <= 1'b0;
			hold_cnt_q <= 9'h0;
			rst_n_q <= 1'b0;
		end else begin
			por_q <= por_d;
			bod_q <= bod_d;
			hold_cnt_q <= hold_cnt_d;
			rst_n_q <= rst_n_d;
		end
	end

	// ==========================================================
	// Power state machine
	psrs_state_t state_q;
	psrs_state_t state_d;
	always_comb begin
		state_d = state_q;
		case (state_q)
			PSRS_CORE_OFF: begin
				if (enable && rst_n_q) begin
					state_d = PSRS_PROC_ONLY;
				end
			end
			PSRS_PROC_ONLY, PSRS_RADIO_TX, PSRS_RADIO_RX, PSRS_DEEP_SLEEP: begin
				if (cmd_valid_i) begin
					case (cmd_i)
						PSRS_CMD_RADIO_TX: state_d = PSRS_RADIO_TX;
						PSRS_CMD_RADIO_RX: state_d = PSRS_RADIO_RX;
						PSRS_CMD_DEEP_SLEEP: state_d = PSRS_DEEP_SLEEP;
						default: state_d = PSRS_PROC_ONLY;
					endcase
				end
			end
			default: state_d = PSRS_CORE_OFF;
		endcase
		// Losing enable or reset always wins over a software command.
		if (!enable || !rst_n_q) begin
			state_d = PSRS_CORE_OFF;
		end
	end
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= PSRS_CORE_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// Clock selection and crystal settings
	function automatic logic [10:0] cap_cpf(input logic [2:0] code, input logic boost);
		logic [10:0] v;
		v = 11'(`PSRS_CAP_BASE_CPF) + 11'(code) * 11'(`PSRS_CAP_STEP_CPF);
		if (boost) begin
			v = v + 11'(`PSRS_CAP_BOOST_CPF);
		end
		return v;
	endfunction

	logic radio_d;
	logic proc_d;
	logic xo_sel_q;
	logic xo_sel_d;
	logic lp_div_q;
	logic lp_div_d;
	logic [10:0] cap_q;
	logic [10:0] cap_d;
	logic [`PSRS_CAL_W-1:0] cal_q;
	logic [`PSRS_CAL_W-1:0] cal_d;
	logic [`PSRS_BOD_W-1:0] bth_q;
	logic [`PSRS_BOD_W-1:0] bth_d;
	logic radio_q;
	logic proc_q;
	logic sclk_q;
	logic sclk_d;
	always_comb begin
		radio_d = (state_d == PSRS_RADIO_TX) || (state_d == PSRS_RADIO_RX);
		proc_d = radio_d || (state_d == PSRS_PROC_ONLY);
		xo_sel_d = radio_d || accurate_clk_req_i;
		lp_div_d = !low_power_clk_fast_i;
		sclk_d = sleep_clk;
		cap_d = cap_cpf(xo_load_cap_code_i, xo_cap_boost_reg_i[`PSRS_BOOST_BIT]);
		// Fuse value is only captured while the core is held in reset.
		cal_d = rst_n_q ? cal_q : fuse_xo_cal_i;
		bth_d = bod_threshold_i;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			radio_q <= 1'b0;
			proc_q <= 1'b0;
			xo_sel_q <= 1'b0;
			lp_div_q <= 1'b1;
			sclk_q <= 1'b0;
			cap_q <= 11'(`PSRS_CAP_BASE_CPF);
			cal_q <= '0;
			bth_q <= `PSRS_BOD_RESET;
		end else begin
			radio_q <= radio_d;
			proc_q <= proc_d;
			xo_sel_q <= xo_sel_d;
			lp_div_q <= lp_div_d;
			sclk_q <= sclk_d;
			cap_q <= cap_d;
			cal_q <= cal_d;
			bth_q <= bth_d;
		end
	end

	assign power_state_o = state_q;
	assign proc_power_on_o = proc_q;
	assign radio_power_on_o = radio_q;
	assign power_on_reset_flag_o = por_q;
	assign brownout_flag_o = bod_q;
	assign chip_reset_n_o = rst_n_q;
	assign slow_clk_stable_o = stable_q;
	assign proc_clk_sel_xo_o = xo_sel_q;
	assign lp_clk_sel_div_o = lp_div_q;
	assign sleep_clk_o = sclk_q;
	assign bod_threshold_o = bth_q;
	assign xo_load_cap_cpf_o = cap_q;
	assign xo_offset_cal_o = cal_q;
endmodule

// ===== psrs_host_model.sv
// Model of the external controller driving I/O supply and chip enable.
// Assumes the bench changes want_on_i just after a clock edge.
`timescale 1ns/1ps
module psrs_host_model (
	input wire logic mclk_i,
	input wire logic want_on_i,
	output logic io_supply_o,
	output logic chip_enable_o
);
	// ====
	// Sequencing
	// Supply leads enable going up and trails it going down.
	initial begin
		io_supply_o = 1'b0;
		chip_enable_o = 1'b0;
		forever begin
			@(posedge mclk_i);
			if (want_on_i) begin
				io_supply_o <= 1'b1;
				chip_enable_o <= io_supply_o;
			end else begin
				chip_enable_o <= 1'b0;
				io_supply_o <= chip_enable_o;
			end
		end
	end
endmodule

// ===== psrs_seq_assertions.sv
// Port checker of the power-state and reset sequencer.
// Assumes a bind onto psrs_seq; it reads ports only.
`timescale 1ns/1ps
`include "psrs_map.svh"
module psrs_seq_assertions
	import psrs_pkg::*;
#(
	parameter int RC_STABLE_CYC = `PSRS_RC_STABLE_CYC
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic chip_enable_pin_i,
	input wire logic battery_low_cmp_i,
	input wire logic cmd_valid_i,
	input wire logic [2:0] xo_load_cap_code_i,
	input wire logic [1:0] xo_cap_boost_reg_i,
	input wire psrs_pkg::psrs_state_t power_state_o,
	input wire logic proc_power_on_o,
	input wire logic radio_power_on_o,
	input wire logic power_on_reset_flag_o,
	input wire logic brownout_flag_o,
	input wire logic chip_reset_n_o,
	input wire logic slow_clk_stable_o,
	input wire logic proc_clk_sel_xo_o,
	input wire logic [10:0] xo_load_cap_cpf_o
);
	// ====
	// Assertions
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);
	property p_radio;
		radio_power_on_o |-> proc_power_on_o;
	endproperty
	a_radio: assert property (p_radio) else $error("radio without cpu");
	property p_ce;
		!chip_enable_pin_i [*8] |-> power_state_o == PSRS_CORE_OFF;
	endproperty
	a_ce: assert property (p_ce) else $error("on while enable low");
	property p_sw;
		(power_state_o != $past(power_state_o) && power_state_o != PSRS_CORE_OFF
			&& $past(power_state_o) != PSRS_CORE_OFF) |-> $past(cmd_valid_i);
	endproperty
	a_sw: assert property (p_sw) else $error("move without command");
	property p_stab;
		$rose(slow_clk_stable_o) |-> $past(chip_enable_pin_i, RC_STABLE_CYC);
	endproperty
	a_stab: assert property (p_stab) else $error("slow clock trusted early");
	property p_por;
		battery_low_cmp_i [*8] |-> power_on_reset_flag_o;
	endproperty
	a_por: assert property (p_por) else $error("por flag low");
	property p_hold;
		(power_on_reset_flag_o || brownout_flag_o) |=> !chip_reset_n_o;
	endproperty
	a_hold: assert property (p_hold) else $error("reset released by flag");
	property p_xo;
		power_state_o inside {PSRS_RADIO_TX, PSRS_RADIO_RX} |-> proc_clk_sel_xo_o;
	endproperty
	a_xo: assert property (p_xo) else $error("radio on rc clock");
	property p_cap;
		1'b1 |=> xo_load_cap_cpf_o == 11'h064 + 11'h07d * $past(xo_load_cap_code_i)
			+ (($past(xo_cap_boost_reg_i) >= 2'h2) ? 11'h1f4 : 11'h000);
	endproperty
	a_cap: assert property (p_cap) else $error("load cap wrong");
	c_tx: cover property (power_state_o == PSRS_RADIO_TX);
	c_rel: cover property ($rose(chip_reset_n_o));
	c_bod: cover property ($rose(brownout_flag_o));
endmodule

// ===== psrs_seq_tb_top.sv
// Self-checking bench of the power-state and reset sequencer.
// Assumes package, sequencer, checker and host model compile first.
`timescale 1ns/1ps
module psrs_seq_tb_top;
	import psrs_pkg::*;
	// RC half period is shortened so the reset hold fits the run.
	localparam int RC_HALF = 20;
	localparam int RC_CYC = 2 * RC_HALF / 4;
	localparam int SLOW_CYC = 64 * RC_CYC;
	localparam int HOLD_CYC = 4 * SLOW_CYC;
	logic mclk_i, rstn_i, want_on, io_sup, ce, bat_low, bg_low, rc, cmd_v, acc;
	logic lp_fast, stab, sclk;
	psrs_cmd_t cmd;
	logic [2:0] cap_code;
	logic [1:0] boost;
	logic [7:0] fuse, cal;
	psrs_state_t state;
	logic proc_on, radio_on, por, brownout_flag, rst_n, xo_sel, lp_div;
	logic [3:0] bth;
	logic [10:0] cap;
	int err_total, n_checks, cyc, n;
	psrs_host_model u_host (.mclk_i(mclk_i), .want_on_i(want_on), .io_supply_o(io_sup),
		.chip_enable_o(ce));
	psrs_seq #(.RST_PERIODS(4), .RC_STABLE_CYC(8)) dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.io_supply_i(io_sup), .chip_enable_pin_i(ce), .battery_low_cmp_i(bat_low),
		.bandgap_low_cmp_i(bg_low), .slow_rc_clk_i(rc), .cmd_valid_i(cmd_v), .cmd_i(cmd),
		.accurate_clk_req_i(acc), .low_power_clk_fast_i(lp_fast), .bod_threshold_i(4'h3),
		.xo_load_cap_code_i(cap_code), .xo_cap_boost_reg_i(boost), .fuse_xo_cal_i(fuse),
		.power_state_o(state), .proc_power_on_o(proc_on), .radio_power_on_o(radio_on),
		.power_on_reset_flag_o(por), .brownout_flag_o(brownout_flag), .chip_reset_n_o(rst_n),
		.slow_clk_stable_o(stab), .proc_clk_sel_xo_o(xo_sel), .lp_clk_sel_div_o(lp_div),
		.sleep_clk_o(sclk), .bod_threshold_o(bth), .xo_load_cap_cpf_o(cap),
		.xo_offset_cal_o(cal));
	// ====
	// Clocks and tasks
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	initial begin
		rc = 1'b0;
		forever #RC_HALF rc = ~rc;
	end
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic sleep_period(output int cnt);
		cnt = 0;
		while (sclk !== 1'b0) begin
			step(1);
		end
		while (sclk !== 1'b1) begin
			step(1);
		end
		while (sclk !== 1'b0) begin
			step(1);
			cnt++;
		end
		while (sclk !== 1'b1) begin
			step(1);
			cnt++;
		end
	endtask
	task automatic power_up();
		int i;
		logic ok;
		want_on = 1'b1;
		i = 0;
		while (state !== PSRS_PROC_ONLY && i < 20000) begin
			step(1);
			i++;
		end
		ok = (i >= HOLD_CYC - RC_CYC) && (i <= HOLD_CYC + 4 * RC_CYC);
		chk({state, proc_on, radio_on, rst_n, ok}, 11'h01b);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ====
	// Sequence
	initial begin
		{rstn_i, want_on, cmd_v, acc, lp_fast, bg_low, cap_code, boost} = '0;
		bat_low = 1'b1;
		cmd = PSRS_CMD_RADIO_TX;
		fuse = 8'h5a;
		step(8);
		chk({state, por, brownout_flag, rst_n, lp_div, bth}, 11'h098);
		chk(11'(cap), 11'h064);
		rstn_i = 1'b1;
		cmd_v = 1'b1;
		step(1);
		cmd_v = 1'b0;
		step(12);
		chk({state, por}, 11'h001);
		bat_low = 1'b0;
		step(12);
		chk(11'(por), 11'h000);
		power_up();
		fuse = 8'ha5;
		cmd_v = 1'b1;
		for (int k = 0; k < 4; k++) begin
			cmd = psrs_cmd_t'(2'(k + 1));
			step(1);
			chk({state, radio_on, xo_sel}, {3'((k + 1) % 4 + 1), 1'(k < 2), 1'(k < 2)});
		end
		cmd_v = 1'b0;
		acc = 1'b1;
		step(3);
		chk({xo_sel, cal}, 11'h15a);
		acc = 1'b0;
		step(3);
		chk(11'(xo_sel), 11'h000);
		for (int c = 0; c < 16; c++) begin
			{boost[1], cap_code} = 4'(c);
			step(2);
			chk(cap, 11'(11'h064 + 11'h07d * (c % 8) + (c > 7 ? 11'h1f4 : 11'h000)));
		end
		bg_low = 1'b1;
		step(12);
		chk({brownout_flag, rst_n, state}, 11'h010);
		bg_low = 1'b0;
		step(HOLD_CYC / 2);
		bg_low = 1'b1;
		step(12);
		bg_low = 1'b0;
		power_up();
		sleep_period(n);
		chk(11'(n), 11'(SLOW_CYC));
		lp_fast = 1'b1;
		step(2);
		chk({stab, lp_div, bth}, 11'h023);
		want_on = 1'b0;
		step(12);
		chk({state, proc_on}, 11'h000);
		wrap_up();
	end
endmodule
bind psrs_seq psrs_seq_assertions #(.RC_STABLE_CYC(RC_STABLE_CYC)) u_chk (.mclk_i(mclk_i),
	.rstn_i(rstn_i), .chip_enable_pin_i(chip_enable_pin_i), .cmd_valid_i(cmd_valid_i),
	.battery_low_cmp_i(battery_low_cmp_i), .xo_load_cap_code_i(xo_load_cap_code_i),
	.xo_cap_boost_reg_i(xo_cap_boost_reg_i), .power_state_o(power_state_o),
	.proc_power_on_o(proc_power_on_o), .radio_power_on_o(radio_power_on_o),
	.power_on_reset_flag_o(power_on_reset_flag_o), .brownout_flag_o(brownout_flag_o),
	.chip_reset_n_o(chip_reset_n_o), .slow_clk_stable_o(slow_clk_stable_o),
	.proc_clk_sel_xo_o(proc_clk_sel_xo_o), .xo_load_cap_cpf_o(xo_load_cap_cpf_o));
